// file: core/flash_host_regs.svh
// Register offsets, field positions, reset values and timing counts of the flash host controller.
// Assumes a 40 MHz clock; times in ns become cycles here.
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// System clock rate in MHz.
`define FH_CLK_MHZ 40
// Time in ns to cycles, rounded up; every time here is positive.
`define FH_CYC(ns) (((ns) * `FH_CLK_MHZ + 999) / 1000)

// Register byte offsets on the Wishbone side.
`define FH_REG_CTRL 8'h00
`define FH_REG_ADDR 8'h04
`define FH_REG_WDATA 8'h08
`define FH_REG_RDATA 8'h0C
`define FH_REG_STATUS 8'h10

// Control register fields.
`define FH_CTRL_START 0
`define FH_CTRL_OP_LO 1
`define FH_CTRL_OP_HI 2
`define FH_CTRL_WORD 3
`define FH_CTRL_ACCEL 4

// Status register fields.
`define FH_ST_BUSY 0
`define FH_ST_RDY 1
`define FH_ST_ACCEL 2
`define FH_ST_ABORTED 3
`define FH_ST_PROG_CYCLES_LO 4
`define FH_ST_PROG_CYCLES_HI 6

// Reset value of the control register: word mode, no acceleration.
`define FH_CTRL_RESET 32'h0000_0008

// Program sequence lengths in write cycles.
`define FH_PROG_CYCLES_NORMAL 3'h4
`define FH_PROG_CYCLES_SHORT 3'h2

// Pin timing in ns.
`define FH_ADDR_ACCESS_NS 90
`define FH_CE_ACCESS_NS 90
`define FH_WE_PULSE_NS 50
`define FH_RESET_MIN_PULSE_NS 500
`define FH_RESET_RECOVERY_NS 50
`define FH_READY_BUSY_NS 20000
`define FH_READY_IDLE_NS 500

// Derived cycle counts.
`define FH_ACCESS_CYC `FH_CYC(`FH_CE_ACCESS_NS > `FH_ADDR_ACCESS_NS ? `FH_CE_ACCESS_NS : `FH_ADDR_ACCESS_NS)
`define FH_WE_PULSE_CYC `FH_CYC(`FH_WE_PULSE_NS)
`define FH_RESET_MIN_PULSE_CYC `FH_CYC(`FH_RESET_MIN_PULSE_NS)
`define FH_RESET_RECOVERY_CYC `FH_CYC(`FH_RESET_RECOVERY_NS)
`define FH_READY_BUSY_CYC `FH_CYC(`FH_READY_BUSY_NS)
`define FH_READY_IDLE_CYC `FH_CYC(`FH_READY_IDLE_NS)

`endif

// file: core/flash_host_pkg.sv
// Types shared by the flash host controller and its bus-cycle engine.
// Assumes the timing and offsets come from flash_host_regs.svh.
package flash_host_pkg;

  // Operations that software can start.
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_RESET = 2'h2,
    OP_NONE = 2'h3
  } op_t;

  // Flash strobe and data pins as the controller drives them.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [19:0] addr;
    logic [15:0] dq;
    logic [15:0] dq_oe;
  } flash_pins_t;

  // One bus cycle request towards the engine.
  typedef struct packed {
    logic write;
    logic word_mode;
    logic [20:0] addr;
    logic [15:0] data;
  } cycle_req_t;

endpackage

// file: core/flash_delay_timer.sv
// Down-counter for one pin delay in clock cycles.
// Assumes the caller loads one or more and watches the zero flag.
`timescale 1ns/1ps
module flash_delay_timer (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Load request and count.
  input wire logic load_i,
  input wire logic [11:0] value_i,
  // Count has run out.
  output logic zero_o
);

  logic [11:0] cnt_q; // Remaining cycles.
  logic [11:0] cnt_d; // Next count.

  // A load wins over counting so a back-to-back delay restarts cleanly.
  always_comb
  begin
    cnt_d = load_i ? value_i : cnt_q - 12'(cnt_q != 12'h000);
  end

  // Count register.
  always_ff @(posedge clk_i)
  begin
    cnt_q <= rst_i ? 12'h000 : cnt_d;
  end

  assign zero_o = (cnt_q == 12'h000);

endmodule

// file: core/flash_bus_cycle.sv
// One read or write cycle on the flash strobes, address and data pins.
// Assumes start_i is a one-cycle pulse given only while busy_o is low.
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_bus_cycle (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Request.
  input wire logic start_i,
  input wire flash_host_pkg::cycle_req_t req_i,
  // Pins.
  input wire logic [15:0] dq_i,
  output flash_host_pkg::flash_pins_t pins_o,
  // Result.
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o
);

  // Engine phases, one-hot.
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_SETUP = 4'b0010,
    PH_ACTIVE = 4'b0100,
    PH_HOLD = 4'b1000
  } phase_t;

  phase_t ph_q, ph_d; // Phase.
  logic [11:0] cnt_q, cnt_d; // Strobe-low cycles left.
  flash_host_pkg::cycle_req_t req_q, req_d; // Latched request.
  flash_host_pkg::flash_pins_t pins_q, pins_d; // Pin registers.
  logic done_q, done_d; // End-of-cycle pulse.
  logic [15:0] rdata_q, rdata_d; // Captured read data.

  // Phase sequencing and pin values.
  always_comb
  begin
    ph_d = ph_q;
    cnt_d = cnt_q;
    req_d = req_q;
    pins_d = pins_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    case (ph_q)
      PH_IDLE:
      begin
        // Between cycles the chip is deselected so it sits in standby.
        {pins_d.ce_n, pins_d.oe_n, pins_d.we_n} = 3'b111;
        pins_d.dq_oe = 16'h0000;
        if (start_i)
        begin
          req_d = req_i;
          // In byte mode the top data line carries the lowest address bit.
          pins_d.addr = req_i.word_mode ? req_i.addr[19:0] : req_i.addr[20:1];
          pins_d.dq = req_i.data;
          pins_d.dq[15] = req_i.word_mode ? req_i.data[15] : req_i.addr[0];
          pins_d.dq_oe = req_i.write ? (req_i.word_mode ? 16'hFFFF : 16'h80FF) :
                         (req_i.word_mode ? 16'h0000 : 16'h8000);
          ph_d = PH_SETUP;
        end
      end
      PH_SETUP:
      begin
        // Address has had one cycle to settle before the strobes fall.
        pins_d.ce_n = 1'b0;
        if (req_q.write)
        begin
          pins_d.we_n = 1'b0;
          pins_d.oe_n = 1'b1;
          cnt_d = 12'(`FH_WE_PULSE_CYC);
        end
        else
        begin
          pins_d.oe_n = 1'b0;
          // Full chip-enable access time, since a read always leaves standby.
          cnt_d = 12'(`FH_ACCESS_CYC);
        end
        ph_d = PH_ACTIVE;
      end
      PH_ACTIVE:
      begin
        if (cnt_q > 12'h001)
        begin
          cnt_d = cnt_q - 12'h001;
        end
        else
        begin
          if (!req_q.write)
          begin
            // Byte reads return only the low data lines.
            rdata_d = req_q.word_mode ? dq_i : {8'h00, dq_i[7:0]};
          end
          pins_d.we_n = 1'b1;
          pins_d.oe_n = 1'b1;
          ph_d = PH_HOLD;
        end
      end
      PH_HOLD:
      begin
        // Data and address are held one cycle past the rising strobe.
        pins_d.ce_n = 1'b1;
        pins_d.dq_oe = 16'h0000;
        done_d = 1'b1;
        ph_d = PH_IDLE;
      end
      default:
      begin
        ph_d = PH_IDLE;
      end
    endcase
  end

  // Engine registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ph_q <= PH_IDLE;
      cnt_q <= 12'h000;
      req_q <= '0;
      pins_q <= {3'b111, 52'h0_0000_0000_0000}; // Strobes high, all else zero.
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      pins_q <= pins_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign pins_o = pins_q;
  assign busy_o = (ph_q != PH_IDLE);
  assign done_o = done_q;
  assign rdata_o = rdata_q;

endmodule

// file: core/flash_host_ctrl.sv
// Host controller for a parallel flash, with a Wishbone register slave.
// Assumes pins synchronous to clk_i; an external switch makes the high voltage.
//
// Operation
// - Commands written with write and chip enables low
// - High voltage selects shortcut mode
// - Wait chip-enable access time after standby
// - Host restarts operations aborted by reset; the controller only sets the sticky aborted status bit for software
// - No read before reset recovery time elapses
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_host_ctrl (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash strobes and address.
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_reset_n_o,
  output logic flash_byte_n_o,
  output logic [19:0] flash_addr_o,
  // Flash data lines.
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe_o,
  // High-voltage request and ready/busy.
  output logic protect_accelerate_input_o,
  input wire logic ready_busy_n_i
);

  // Controller states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CYCLE = 5'b00010,
    ST_RST_LOW = 5'b00100,
    ST_RST_READY = 5'b01000,
    ST_RST_RECOVER = 5'b10000
  } state_t;

  // Wishbone byte-lane merge.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction

  state_t st_q, st_d; // Controller state.
  logic [31:0] ctrl_q, ctrl_d; // Control register.
  logic [31:0] addr_q, addr_d; // Flash address register.
  logic [31:0] wdata_q, wdata_d; // Write data register.
  logic aborted_q, aborted_d; // Sticky: a reset hit a running operation.
  logic rb_at_rst_q, rb_at_rst_d; // Ready/busy seen when reset was applied.
  logic reset_n_q, reset_n_d; // Flash reset pin register.
  logic accel_q, accel_d; // High-voltage request register.
  logic byte_n_q, byte_n_d; // Width select register.
  logic ack_q, ack_d; // Wishbone acknowledge.
  logic [31:0] dat_q, dat_d; // Wishbone read data.
  logic tmr_load; // Timer load strobe.
  logic [11:0] tmr_value; // Timer load value.
  logic tmr_zero; // Timer has run out.
  logic cyc_start; // Engine start pulse.
  flash_host_pkg::cycle_req_t cyc_req; // Engine request.
  flash_host_pkg::flash_pins_t pins; // Engine pin registers.
  logic cyc_busy; // Engine is running.
  logic cyc_done; // Engine finished.
  logic [15:0] cyc_rdata; // Engine read data.
  logic bus_req; // A Wishbone access is at its ack edge.
  logic ctrl_wr; // Software writes the control register.
  logic start_req; // Software asks for an operation.
  flash_host_pkg::op_t op_req; // Operation asked for.
  logic [2:0] prog_cycles; // Write cycles software must issue per program.

  assign bus_req = wb_cyc_i && wb_stb_i && ack_q;
  assign ctrl_wr = bus_req && wb_we_i && (wb_adr_i == `FH_REG_CTRL);
  assign start_req = ctrl_wr && wb_sel_i[0] && wb_dat_i[`FH_CTRL_START];
  assign op_req = flash_host_pkg::op_t'(wb_dat_i[`FH_CTRL_OP_HI:`FH_CTRL_OP_LO]);
  // While the high voltage is applied the device expects the short sequence.
  assign prog_cycles = accel_q ? `FH_PROG_CYCLES_SHORT : `FH_PROG_CYCLES_NORMAL;

  // Delay timer for the reset pulse, ready wait and recovery.
  flash_delay_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .value_i(tmr_value),
    .zero_o(tmr_zero)
  );

  // Single read or write cycle on the pins.
  flash_bus_cycle u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(cyc_start),
    .req_i(cyc_req),
    .dq_i(flash_dq_i),
    .pins_o(pins),
    .busy_o(cyc_busy),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata)
  );

  // Wishbone slave: ack one cycle after the request, dropped the next cycle.
  always_comb
  begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    dat_d = dat_q;
    if (ack_d)
    begin
      case (wb_adr_i)
        `FH_REG_CTRL: dat_d = {ctrl_q[31:1], 1'b0};
        `FH_REG_ADDR: dat_d = addr_q;
        `FH_REG_WDATA: dat_d = wdata_q;
        `FH_REG_RDATA: dat_d = {16'h0000, cyc_rdata};
        `FH_REG_STATUS:
        begin
          dat_d = 32'h0000_0000;
          dat_d[`FH_ST_BUSY] = (st_q != ST_IDLE);
          dat_d[`FH_ST_RDY] = ready_busy_n_i;
          dat_d[`FH_ST_ACCEL] = accel_q;
          dat_d[`FH_ST_ABORTED] = aborted_q;
          dat_d[`FH_ST_PROG_CYCLES_HI:`FH_ST_PROG_CYCLES_LO] = prog_cycles;
        end
        // Unmapped offsets answer with zero.
        default: dat_d = 32'h0000_0000;
      endcase
    end
  end

  // Register writes take effect at the ack edge.
  always_comb
  begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    if (bus_req && wb_we_i)
    begin
      case (wb_adr_i)
        `FH_REG_CTRL: ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i);
        `FH_REG_ADDR: addr_d = merge(addr_q, wb_dat_i, wb_sel_i);
        `FH_REG_WDATA: wdata_d = merge(wdata_q, wb_dat_i, wb_sel_i);
        default: ctrl_d = ctrl_q;
      endcase
    end
    // The start bit is a strobe and never stays set.
    ctrl_d[`FH_CTRL_START] = 1'b0;
  end

  // Main sequencer: pin cycles and the flash reset pulse.
  always_comb
  begin
    st_d = st_q;
    tmr_load = 1'b0;
    tmr_value = 12'h000;
    cyc_start = 1'b0;
    cyc_req.write = (op_req == flash_host_pkg::OP_WRITE);
    cyc_req.word_mode = ctrl_d[`FH_CTRL_WORD];
    cyc_req.addr = addr_q[20:0];
    cyc_req.data = wdata_q[15:0];
    reset_n_d = reset_n_q;
    rb_at_rst_d = rb_at_rst_q;
    aborted_d = aborted_q;
    // Width and high voltage only change while no cycle is on the pins.
    accel_d = accel_q;
    byte_n_d = byte_n_q;
    if (st_q == ST_IDLE)
    begin
      accel_d = ctrl_d[`FH_CTRL_ACCEL];
      byte_n_d = ctrl_d[`FH_CTRL_WORD];
    end
    // Software clears the abort flag by writing one to it.
    if (bus_req && wb_we_i && (wb_adr_i == `FH_REG_STATUS) && wb_sel_i[0] &&
        wb_dat_i[`FH_ST_ABORTED])
    begin
      aborted_d = 1'b0;
    end
    case (st_q)
      ST_IDLE:
      begin
        // Requests while busy are ignored; software polls the busy bit.
        if (start_req)
        begin
          if (op_req == flash_host_pkg::OP_RESET)
          begin
            reset_n_d = 1'b0;
            rb_at_rst_d = ready_busy_n_i;
            tmr_load = 1'b1;
            tmr_value = 12'(`FH_RESET_MIN_PULSE_CYC);
            st_d = ST_RST_LOW;
          end
          else if (op_req != flash_host_pkg::OP_NONE)
          begin
            // Identification and status reads are plain read cycles.
            cyc_start = 1'b1;
            st_d = ST_CYCLE;
          end
        end
      end
      ST_CYCLE:
      begin
        // Address stays on the pins after the cycle, so sleep keeps data.
        if (cyc_done && !cyc_busy)
        begin
          st_d = ST_IDLE;
        end
      end
      ST_RST_LOW:
      begin
        if (tmr_zero)
        begin
          reset_n_d = 1'b1;
          tmr_load = 1'b1;
          // A running operation needs the longer internal reset.
          tmr_value = rb_at_rst_q ? 12'(`FH_READY_IDLE_CYC) : 12'(`FH_READY_BUSY_CYC);
          if (!rb_at_rst_q)
          begin
            // Set wins over a clear written in the same cycle.
            aborted_d = 1'b1;
          end
          st_d = ST_RST_READY;
        end
      end
      ST_RST_READY:
      begin
        // Leave when the ready time is up, or as soon as ready/busy is high if it was low at reset.
        if ((ready_busy_n_i && !rb_at_rst_q) || tmr_zero)
        begin
          tmr_load = 1'b1;
          tmr_value = 12'(`FH_RESET_RECOVERY_CYC);
          st_d = ST_RST_RECOVER;
        end
      end
      ST_RST_RECOVER:
      begin
        // The device is back in array read; no read starts before this ends.
        if (tmr_zero)
        begin
          st_d = ST_IDLE;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // All controller registers; rst_i leaves the flash reset pin high.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= ST_IDLE;
      ctrl_q <= `FH_CTRL_RESET;
      addr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      aborted_q <= 1'b0;
      rb_at_rst_q <= 1'b1;
      reset_n_q <= 1'b1;
      accel_q <= 1'b0;
      byte_n_q <= 1'b1;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      aborted_q <= aborted_d;
      rb_at_rst_q <= rb_at_rst_d;
      reset_n_q <= reset_n_d;
      accel_q <= accel_d;
      byte_n_q <= byte_n_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Outputs come straight from registers here or in the engine.
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign flash_ce_n_o = pins.ce_n;
  assign flash_oe_n_o = pins.oe_n;
  assign flash_we_n_o = pins.we_n;
  assign flash_addr_o = pins.addr;
  assign flash_dq_o = pins.dq;
  assign flash_dq_oe_o = pins.dq_oe;
  assign flash_reset_n_o = reset_n_q;
  assign flash_byte_n_o = byte_n_q;
  assign protect_accelerate_input_o = accel_q;

endmodule

// file: sim/flash_host_chk.sv
// Pin assertions for the flash host controller.
// Assumes a bind to flash_host_ctrl; sees only its ports.
`timescale 1ns/1ps
module flash_host_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone handshake.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Flash pins.
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_reset_n_o,
  input wire logic flash_byte_n_o,
  input wire logic [15:0] flash_dq_oe_o,
  input wire logic protect_accelerate_input_o,
  input wire logic ready_busy_n_i
);
  logic [7:0] low_q; // Cycles the flash reset has been low, saturating.
  logic wait_q; // High while an aborted operation is still winding down.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Helper registers; the counter saturates so a long pulse never wraps short.
  always_ff @(posedge clk_i)
  begin
    low_q <= (rst_i || flash_reset_n_o) ? 8'h00 : low_q + 8'(low_q != 8'hff);
    wait_q <= !rst_i && !ready_busy_n_i && (wait_q || (flash_reset_n_o && low_q != 8'h00));
  end
  sequence s_read_low; (!flash_oe_n_o && !flash_ce_n_o) [*4]; endsequence
  sequence s_we_low; !flash_we_n_o [*2] ##1 flash_we_n_o; endsequence
  property p_cmd; !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o; endproperty
  a_cmd: assert property (p_cmd) else $error("write strobe outside a command cycle");
  property p_we; $fell(flash_we_n_o) |-> s_we_low; endproperty
  a_we: assert property (p_we) else $error("write pulse length wrong");
  property p_read; $fell(flash_oe_n_o) |-> s_read_low ##1 flash_oe_n_o; endproperty
  a_read: assert property (p_read) else $error("read strobe length wrong");
  property p_rst_w; $rose(flash_reset_n_o) |-> low_q >= 8'h14; endproperty
  a_rst_w: assert property (p_rst_w) else $error("flash reset pulse too short");
  property p_recov; $rose(flash_reset_n_o) |-> flash_oe_n_o [*3]; endproperty
  a_recov: assert property (p_recov) else $error("read too soon after reset");
  property p_idle; $rose(flash_reset_n_o) && ready_busy_n_i |-> flash_ce_n_o [*8]; endproperty
  a_idle: assert property (p_idle) else $error("access during idle reset time");
  property p_quiet; !flash_reset_n_o |-> flash_ce_n_o && flash_dq_oe_o == 16'h0000; endproperty
  a_quiet: assert property (p_quiet) else $error("pins active during flash reset");
  property p_byte; !flash_byte_n_o |-> flash_dq_oe_o[14:8] == 7'h00; endproperty
  a_byte: assert property (p_byte) else $error("middle data lines driven in byte mode");
  property p_acc; $changed(protect_accelerate_input_o) |-> flash_ce_n_o; endproperty
  a_acc: assert property (p_acc) else $error("high voltage changed inside a cycle");
  property p_busy; wait_q |-> flash_ce_n_o; endproperty
  a_busy: assert property (p_busy) else $error("access before ready after reset");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus acknowledge timing wrong");
endmodule
bind flash_host_ctrl flash_host_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o, .flash_byte_n_o,
  .flash_dq_oe_o, .protect_accelerate_input_o, .ready_busy_n_i);

// file: sim/flash_dev_model.sv
// Flash device model on the controller's pins.
// Assumes pins change on clk_i edges; commands are counted, not decoded.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] STAT = 16'h004c, // Status pattern while busy, arbitrary.
  parameter int PROG_CYC = 40, // Cycles one program keeps the device busy.
  parameter int RST_CYC = 100 // Cycles an aborted operation holds ready/busy low.
) (
  // Strobes and mode pins.
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic byte_n_i,
  input wire logic accel_i,
  // Address and data.
  input wire logic [19:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic ready_busy_n_o,
  // Observation for the bench.
  output logic [7:0] prog_cnt_o,
  output logic [7:0] early_o,
  output logic [20:0] waddr_o,
  output logic [15:0] wdata_o
);
  logic we_q = 1'b1;
  logic [15:0] last_q = 16'h0000; // Last data put out, kept latched.
  logic [15:0] w;
  int rd_cnt = 0;
  int bcnt = 0; // Busy countdown; zero at power-up means array read mode.
  int seq = 0;
  int since = 1000; // Cycles since reset went high.
  assign ready_busy_n_o = (bcnt == 0);
  assign w = addr_i[15:0] ^ 16'ha5c3;
  // Released lines show the inverse of the last value, never a stale copy.
  always_comb
  begin
    dq_o = ~last_q;
    if (!ce_n_i && !oe_n_i && reset_n_i && rd_cnt >= 3)
      dq_o = bcnt != 0 ? STAT : (byte_n_i ? w : {~last_q[15:8], dq_i[15] ? w[15:8] : w[7:0]});
  end
  // Write capture, program timing and reset handling.
  always @(posedge clk_i)
  begin
    we_q <= we_n_i;
    rd_cnt <= (!ce_n_i && !oe_n_i) ? rd_cnt + 1 : 0;
    since <= reset_n_i ? since + 1 : 0;
    if (!ce_n_i && !oe_n_i && rd_cnt >= 3)
      last_q <= dq_o;
    if (reset_n_i && !ce_n_i && !oe_n_i && rd_cnt == 0 && since < 2)
      early_o <= early_o + 8'h01;
    if (!reset_n_i && since != 0)
    begin
      bcnt <= bcnt != 0 ? RST_CYC : 0;
      seq <= 0;
    end
    else if (bcnt != 0)
      bcnt <= bcnt - 1;
    if (reset_n_i && !we_q && we_n_i && !ce_n_i && oe_n_i)
    begin
      waddr_o <= byte_n_i ? {addr_i, 1'b0} : {addr_i, dq_i[15]};
      wdata_o <= byte_n_i ? dq_i : {8'h00, dq_i[7:0]};
      if (seq + 1 == (accel_i ? 2 : 4))
      begin
        seq <= 0;
        bcnt <= PROG_CYC;
        prog_cnt_o <= prog_cnt_o + 8'h01;
      end
      else
        seq <= seq + 1;
    end
  end
  initial
  begin
    prog_cnt_o = 8'h00;
    early_o = 8'h00;
  end
endmodule

// file: sim/tb_top.sv
// Bench: Wishbone master, flash model and scenario tasks.
// Assumes the register map of flash_host_regs.svh.
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ce_n, oe_n, we_n, rst_n, byte_n, accel, rdy;
  logic [19:0] addr;
  logic [15:0] dq_o, dq_oe, dev_dq, dq_bus;
  logic [7:0] prog_cnt, early;
  logic [20:0] waddr;
  logic [15:0] wdata;
  int error_cnt = 0;
  int checks_done = 0;
  // Each line shows the host's value where it drives, else the device's.
  assign dq_bus = (dq_oe & dq_o) | (~dq_oe & dev_dq);
  always #12.5 clk_i = ~clk_i;
  flash_host_ctrl i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n), .flash_reset_n_o(rst_n), .flash_byte_n_o(byte_n),
    .flash_addr_o(addr), .flash_dq_i(dq_bus), .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe),
    .protect_accelerate_input_o(accel), .ready_busy_n_i(rdy));
  flash_dev_model i_dev (.clk_i(clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .reset_n_i(rst_n), .byte_n_i(byte_n), .accel_i(accel), .addr_i(addr), .dq_i(dq_bus),
    .dq_o(dev_dq), .ready_busy_n_o(rdy), .prog_cnt_o(prog_cnt), .early_o(early),
    .waddr_o(waddr), .wdata_o(wdata));
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // One classic Wishbone cycle; the request holds until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && ++n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      results();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0000_0000, q);
  endtask
  // Polls status until the masked bits match, bounded.
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] s;
    for (int n = 0; n < 400; n++)
    begin
      rd(`FH_REG_STATUS, s);
      if ((s & m) === v)
        return;
    end
    error_cnt++;
    results();
  endtask
  // Starts one flash operation and waits until idle.
  task automatic fop(input logic [31:0] c);
    wr(`FH_REG_CTRL, c);
    wait_st(32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic t_reset_vals();
    logic [31:0] q;
    rd(`FH_REG_CTRL, q);
    chk("ctrl reset", 32'h0000_0008, q);
    rd(`FH_REG_STATUS, q);
    chk("status reset", 32'h0000_0042, q);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, q);
    chk("unmapped read", 32'h0000_0000, q);
    chk("standby pins", 32'h0000_0001, {31'h0, ce_n & rst_n});
    $display("test reset_vals done");
  endtask
  // One word read with no command first.
  task automatic t_read(input logic [19:0] a);
    logic [31:0] q;
    wr(`FH_REG_ADDR, {12'h000, a});
    fop(32'h0000_0009);
    rd(`FH_REG_RDATA, q);
    chk("word read", {16'h0000, a[15:0] ^ 16'ha5c3}, q);
    $display("test read done");
  endtask
  task automatic t_byte();
    logic [31:0] q;
    wr(`FH_REG_ADDR, 32'h0000_0013);
    wr(`FH_REG_WDATA, 32'h0000_00ab);
    fop(32'h0000_0003);
    chk("byte write addr", 32'h0000_0013, 32'(waddr));
    chk("byte write data", 32'h0000_00ab, 32'(wdata));
    fop(32'h0000_0001);
    rd(`FH_REG_RDATA, q);
    chk("byte read", 32'h0000_00a5, q);
    $display("test byte done");
  endtask
  // One program sequence; c selects accelerated or normal mode.
  task automatic t_prog(input logic [31:0] c, input int n);
    logic [31:0] q;
    logic [7:0] p;
    wr(`FH_REG_CTRL, c);
    rd(`FH_REG_STATUS, q);
    chk("mode status", c[4] ? 32'h0000_0026 : 32'h0000_0042, q);
    chk("accel pin", 32'(c[4]), 32'(accel));
    p = prog_cnt;
    for (int i = 0; i < n; i++)
    begin
      wr(`FH_REG_ADDR, i);
      wr(`FH_REG_WDATA, i);
      fop(c | 32'h0000_0003);
      if (i == n - 2)
        chk("no early program", 32'(p), 32'(prog_cnt));
    end
    chk("program count", 32'(p + 8'h01), 32'(prog_cnt));
    fop(c | 32'h0000_0001);
    rd(`FH_REG_RDATA, q);
    chk("busy status read", 32'h0000_004c, q);
    wait_st(32'h0000_0002, 32'h0000_0002);
    $display("test prog done");
  endtask
  task automatic t_rst(input logic busy);
    logic [31:0] q;
    logic [7:0] p;
    p = prog_cnt;
    if (busy)
      for (int i = 0; i < 4; i++)
        fop(32'h0000_000b);
    fop(32'h0000_000d);
    rd(`FH_REG_STATUS, q);
    chk("reset status", busy ? 32'h0000_004a : 32'h0000_0042, q);
    wr(`FH_REG_STATUS, 32'h0000_0008);
    rd(`FH_REG_STATUS, q);
    chk("abort cleared", 32'h0000_0042, q);
    chk("early reads", 32'h0000_0000, 32'(early));
    t_read(20'h00055);
    for (int i = 0; i < 4; i++)
      fop(32'h0000_000b);
    chk("restart program", 32'(p + (busy ? 8'h02 : 8'h01)), 32'(prog_cnt));
    wait_st(32'h0000_0002, 32'h0000_0002);
    $display("test reset done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_vals();
    t_read(20'h01234);
    t_read(20'h0fff0);
    t_prog(32'h0000_0018, 2);
    t_prog(32'h0000_0008, 4);
    t_rst(1'b1);
    t_rst(1'b0);
    t_byte();
    results();
  end
endmodule
